// [fsa_chk.sv]
// Port-level assertions for the fault status aggregator.
`timescale 1ns/1ns
module fsa_chk
  import fsa_pkg::*;
(
  input wire logic          clk,
  input wire logic          srst,
  input fsa_rail_t          rail_in,
  input wire logic          board_temp_oob,
  input fsa_port_t          port_in,
  input fsa_algo_t          algo_in,
  input wire logic          cal_checksum_bad,
  input wire logic [3:0]    hw_cond,
  input wire logic          link_cond,
  input wire logic [3:0]    sw_cond,
  input wire logic          sense_cond,
  input fsa_cmd_t           cmd,
  input fsa_rsp_t           rsp,
  input wire logic [15:0]   health_word,
  input wire logic          hw_fault_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Two clean edges behind us, so the two-deep history holds no reset values
  sequence s_settled;
    !$past(srst) && !$past(srst, 2);
  endsequence
  // A field request taken at this edge
  sequence s_req;
    cmd.rd || cmd.wr;
  endsequence
  a_hw_summary: assert property (s_settled |->
    health_word[1] == (|$past(rail_in, 2) || $past(board_temp_oob, 2)))
    else $error("hw error bit off");
  a_link_summary: assert property (s_settled |->
    health_word[2] == |$past(port_in, 2)) else $error("link error bit off");
  a_sw_summary: assert property (s_settled |->
    health_word[3] == (|$past(algo_in, 2) || $past(cal_checksum_bad, 2)))
    else $error("sw error bit off");
  a_alert_or: assert property (health_word[8] == |health_word[12:9])
    else $error("overall alert is not the or of four");
  a_reserved_zero: assert property (health_word[7:4] == 4'h0 && health_word[15:13] == 3'h0)
    else $error("reserved health bit set");
  a_fault_mirror: assert property (hw_fault_out == health_word[0])
    else $error("fault pin differs from fatal bit");
  a_hard_fatal: assert property ((|algo_in || cal_checksum_bad) |-> ##3 health_word[0])
    else $error("hard failure did not turn fatal");
  a_fatal_sticky: assert property (health_word[0] |=> health_word[0])
    else $error("fatal bit dropped without reset");
  a_req_answer: assert property (s_req |=> rsp.done)
    else $error("request not answered");
  a_clash_refused: assert property (cmd.rd && cmd.wr |=> rsp.err)
    else $error("read and write together not refused");
endmodule : fsa_chk

bind fsa_fault_status_aggregator fsa_chk i_chk (.*);

// [fsa_fault_status_aggregator.sv]
// Built-in-test flag aggregation, health word and field command port.
`timescale 1ns/1ns
module fsa_fault_status_aggregator
  import fsa_pkg::*;
#(
  parameter int         WINDOW_CYCLES = FSA_WINDOW_CYCLES,
  parameter logic [7:0] SOFT_THRESH   = FSA_THRESH_DEFAULT
) (
  input  wire logic clk,
  input  wire logic srst,
  input  fsa_rail_t rail_in,
  input  wire logic board_temp_oob,
  input  fsa_port_t port_in,
  input  fsa_algo_t algo_in,
  input  wire logic cal_checksum_bad,
  input  wire logic [FSA_HWC_W-1:0] hw_cond,
  input  wire logic link_cond,
  input  wire logic [FSA_SWC_W-1:0] sw_cond,
  input  wire logic sense_cond,
  input  fsa_cmd_t  cmd,
  output fsa_rsp_t  rsp,
  output logic [15:0] health_word,
  output logic      hw_fault_out
);

  // Or of the enabled bits of a condition field
  function automatic logic fsa_gate(input logic [15:0] cond, input logic [15:0] mask);
    fsa_gate = |(cond & mask);
  endfunction : fsa_gate

  // Zero-extend a narrow field to a 16-bit word; reserved bits stay zero
  function automatic logic [15:0] fsa_pad(input logic [15:0] raw, input int width);
    logic [15:0] keep;
    keep = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      keep[i] = (i < width);
    end
    fsa_pad = raw & keep;
  endfunction : fsa_pad

  // Low-level error fields, snapshots of the monitors
  logic [15:0] power_rail_errors;        // Rail flags
  logic [15:0] environment_errors;       // Temperature flag
  logic [15:0] user_port_errors;         // Serial port A flags
  logic [15:0] algorithm_errors;         // Algorithm hard flags
  logic [15:0] calibration_data_errors;  // Calibration data flag

  // Status condition fields
  logic [15:0] hw_cond_field;            // Hardware conditions
  logic [15:0] link_cond_field;          // Communication conditions
  logic [15:0] sw_cond_field;            // Software conditions
  logic [15:0] sense_cond_field;         // Sensor conditions

  // Host enable masks
  logic [15:0] hw_alert_mask;            // Hardware alert enables
  logic [15:0] link_alert_mask;          // Communication alert enables
  logic [15:0] sw_alert_mask;            // Software alert enables
  logic [15:0] sense_alert_mask;         // Sensor alert enables

  // Intermediate flags
  logic        rail_fault;               // Any rail out of bounds
  logic        ambient_fault;            // Any environment flag
  logic        user_port_fault;          // Any port A flag
  logic        second_port_fault;        // Second port, not built
  logic        algo_fault;               // Any algorithm flag
  logic        cal_data_fault;           // Any data flag
  logic        hw_fault_flag;            // Hardware error summary
  logic        link_fault_flag;          // Communication error summary
  logic        sw_fault_flag;            // Software error summary
  logic        hw_alert_flag;            // Enabled hardware alert
  logic        link_alert_flag;          // Enabled communication alert
  logic        sw_alert_flag;            // Enabled software alert
  logic        sense_alert_flag;         // Enabled sensor alert
  logic        overall_alert_flag;       // Any enabled alert
  logic        fatal_flag;               // Fatal error has occurred

  // Summary words
  logic [15:0] hardware_error_summary;   // Rail and environment bits
  logic [15:0] link_error_summary;       // Port bits
  logic [15:0] software_error_summary;   // Algorithm and data bits
  logic [15:0] next_health;              // Assembled health word

  // Soft error qualification
  logic [FSA_NUM_SOFT-1:0] soft_vec;     // All soft flags in one vector
  logic [FSA_NUM_SOFT-1:0] soft_persist; // Flags past their threshold
  logic [FSA_WIN_CNT_W-1:0] win_count;   // Window down-counter
  logic                    win_tick;     // One pulse per window
  logic                    hard_hit;     // Any instantly fatal flag

  // Health state
  fsa_state_t state;                     // Present health state
  fsa_state_t next_state;                // Next health state

  // Command decode results
  logic        id_known;                 // Field id is mapped
  logic        id_writable;              // Field id is a mask
  logic [15:0] rd_value;                 // Data of the addressed field

  // Snapshot the error monitors; reserved bits are forced to zero
  always_ff @(posedge clk) begin
    if (srst) begin
      power_rail_errors       <= FSA_FIELD_RST;
      environment_errors      <= FSA_FIELD_RST;
      user_port_errors        <= FSA_FIELD_RST;
      algorithm_errors        <= FSA_FIELD_RST;
      calibration_data_errors <= FSA_FIELD_RST;
    end else begin
      power_rail_errors       <= fsa_pad(16'(rail_in), FSA_RAIL_W);   // [R9] [R22]
      environment_errors      <= fsa_pad(16'(board_temp_oob), 1);     // [R10] [R22]
      user_port_errors        <= fsa_pad(16'(port_in), FSA_PORT_W);   // [R12] [R22]
      algorithm_errors        <= fsa_pad(16'(algo_in), FSA_ALGO_W);   // [R15] [R22]
      calibration_data_errors <= fsa_pad(16'(cal_checksum_bad), 1);   // [R16] [R22]
    end
  end

  // Snapshot the status conditions with their reserved bits cleared
  always_ff @(posedge clk) begin
    if (srst) begin
      hw_cond_field    <= FSA_FIELD_RST;
      link_cond_field  <= FSA_FIELD_RST;
      sw_cond_field    <= FSA_FIELD_RST;
      sense_cond_field <= FSA_FIELD_RST;
    end else begin
      hw_cond_field    <= fsa_pad(16'(hw_cond), FSA_HWC_W);   // [R22]
      link_cond_field  <= fsa_pad(16'(link_cond), 1);         // [R22]
      sw_cond_field    <= fsa_pad(16'(sw_cond), FSA_SWC_W);   // [R22]
      sense_cond_field <= fsa_pad(16'(sense_cond), 1);        // [R22]
    end
  end

  // Leaf-to-parent reductions
  assign rail_fault        = |power_rail_errors;        // [R7]
  assign ambient_fault     = |environment_errors;       // [R8]
  assign user_port_fault   = |user_port_errors;         // [R11]
  assign second_port_fault = 1'b0;                      // Second port not built [R11]
  assign algo_fault        = |algorithm_errors;         // [R13]
  assign cal_data_fault    = |calibration_data_errors;  // [R14]

  // Summary words, bits above the used ones read zero
  always_comb begin
    hardware_error_summary = 16'h0000;
    link_error_summary     = 16'h0000;
    software_error_summary = 16'h0000;
    hardware_error_summary[FSA_HW_RAIL] = rail_fault;         // [R7]
    hardware_error_summary[FSA_HW_ENV]  = ambient_fault;      // [R8]
    link_error_summary[FSA_LINK_PORT]   = user_port_fault;    // [R11]
    link_error_summary[FSA_LINK_PORT+1] = second_port_fault;  // [R22]
    software_error_summary[FSA_SW_ALGO] = algo_fault;         // [R13]
    software_error_summary[FSA_SW_CAL]  = cal_data_fault;     // [R14]
  end

  // Category error flags
  assign hw_fault_flag   = |hardware_error_summary;  // [R2]
  assign link_fault_flag = |link_error_summary;      // [R3]
  assign sw_fault_flag   = |software_error_summary;  // [R4]

  // Alert flags gated by the host masks
  assign hw_alert_flag    = fsa_gate(hw_cond_field, hw_alert_mask);        // [R6]
  assign link_alert_flag  = fsa_gate(link_cond_field, link_alert_mask);    // [R17]
  assign sw_alert_flag    = fsa_gate(sw_cond_field, sw_alert_mask);        // [R17]
  assign sense_alert_flag = fsa_gate(sense_cond_field, sense_alert_mask);  // [R17]
  assign overall_alert_flag = hw_alert_flag | link_alert_flag |
                              sw_alert_flag | sense_alert_flag;            // [R21]

  // Window timer; the counter drains one occurrence per window
  always_ff @(posedge clk) begin
    if (srst) begin
      win_count <= FSA_WIN_CNT_W'(WINDOW_CYCLES - 1);
    end else if (win_count == '0) begin
      win_count <= FSA_WIN_CNT_W'(WINDOW_CYCLES - 1);  // [R18]
    end else begin
      win_count <= win_count - 1'b1;
    end
  end

  assign win_tick = (win_count == '0);

  // All soft flags in one vector: rails, then temperature, then port
  assign soft_vec = {user_port_errors[FSA_PORT_W-1:0],
                     environment_errors[0],
                     power_rail_errors[FSA_RAIL_W-1:0]};

  // One qualifier per soft flag so one noisy rail cannot borrow another's count
  for (genvar g = 0; g < FSA_NUM_SOFT; g++) begin : g_soft
    fsa_soft_persist #(
      .THRESH (SOFT_THRESH)
    ) u_persist (
      .clk     (clk),
      .srst    (srst),
      .leak    (win_tick),
      .flag_in (soft_vec[g]),
      .persist (soft_persist[g])
    );  // [R23]
  end

  // Hard flags are fatal at once
  assign hard_hit = algo_fault | cal_data_fault;  // [R19]

  // Fatal latches until reset: a failed unit should not look healthy again
  always_comb begin
    next_state = state;
    case (state)
      FSA_HEALTHY: begin
        if (hard_hit || (|soft_persist)) begin
          next_state = FSA_FAILED;  // [R19] [R18]
        end
      end
      FSA_FAILED: begin
        next_state = FSA_FAILED;
      end
      default: begin
        next_state = FSA_HEALTHY;
      end
    endcase
  end

  // Health state register
  always_ff @(posedge clk) begin
    if (srst) begin
      state <= FSA_HEALTHY;
    end else begin
      state <= next_state;
    end
  end

  assign fatal_flag = (state == FSA_FAILED);  // [R1]

  // Assemble the health word; reserved bits 4-7 and 13-15 stay zero
  always_comb begin
    next_health = 16'h0000;
    next_health[FSA_GH_FATAL]       = fatal_flag;          // [R1]
    next_health[FSA_GH_HW]          = hw_fault_flag;       // [R2]
    next_health[FSA_GH_LINK]        = link_fault_flag;     // [R3]
    next_health[FSA_GH_SW]          = sw_fault_flag;       // [R4]
    next_health[FSA_GH_ALERT]       = overall_alert_flag;  // [R5]
    next_health[FSA_GH_HW_ALERT]    = hw_alert_flag;       // [R5]
    next_health[FSA_GH_LINK_ALERT]  = link_alert_flag;     // [R5]
    next_health[FSA_GH_SW_ALERT]    = sw_alert_flag;       // [R5]
    next_health[FSA_GH_SENSE_ALERT] = sense_alert_flag;    // [R5]
  end

  // Health word and fault pin from flops
  always_ff @(posedge clk) begin
    if (srst) begin
      health_word  <= FSA_FIELD_RST;
      hw_fault_out <= 1'b0;
    end else begin
      health_word  <= next_health;
      hw_fault_out <= fatal_flag;  // [R20]
    end
  end

  // Field id decode for reads
  always_comb begin
    id_known = 1'b1;
    rd_value = 16'h0000;
    if (cmd.id == FSA_ID_HEALTH) begin
      rd_value = next_health;
    end else if (cmd.id == FSA_ID_HW_SUM) begin
      rd_value = hardware_error_summary;
    end else if (cmd.id == FSA_ID_RAIL) begin
      rd_value = power_rail_errors;
    end else if (cmd.id == FSA_ID_ENV) begin
      rd_value = environment_errors;
    end else if (cmd.id == FSA_ID_LINK_SUM) begin
      rd_value = link_error_summary;
    end else if (cmd.id == FSA_ID_PORT) begin
      rd_value = user_port_errors;
    end else if (cmd.id == FSA_ID_SW_SUM) begin
      rd_value = software_error_summary;
    end else if (cmd.id == FSA_ID_ALGO) begin
      rd_value = algorithm_errors;
    end else if (cmd.id == FSA_ID_CAL) begin
      rd_value = calibration_data_errors;
    end else if (cmd.id == FSA_ID_HW_COND) begin
      rd_value = hw_cond_field;
    end else if (cmd.id == FSA_ID_LINK_COND) begin
      rd_value = link_cond_field;
    end else if (cmd.id == FSA_ID_SW_COND) begin
      rd_value = sw_cond_field;
    end else if (cmd.id == FSA_ID_SENSE_COND) begin
      rd_value = sense_cond_field;
    end else if (cmd.id == FSA_ID_HW_MASK) begin
      rd_value = hw_alert_mask;
    end else if (cmd.id == FSA_ID_LINK_MASK) begin
      rd_value = link_alert_mask;
    end else if (cmd.id == FSA_ID_SW_MASK) begin
      rd_value = sw_alert_mask;
    end else if (cmd.id == FSA_ID_SENSE_MASK) begin
      rd_value = sense_alert_mask;
    end else begin
      id_known = 1'b0;  // Unmapped field
    end
  end

  // Only the four masks take writes; error and status fields refuse them
  assign id_writable = (cmd.id == FSA_ID_HW_MASK) || (cmd.id == FSA_ID_LINK_MASK) ||
                       (cmd.id == FSA_ID_SW_MASK) || (cmd.id == FSA_ID_SENSE_MASK);

  // Mask registers, written by the host field-write command
  always_ff @(posedge clk) begin
    if (srst) begin
      hw_alert_mask    <= FSA_HW_MASK_RST;
      link_alert_mask  <= FSA_LINK_MASK_RST;
      sw_alert_mask    <= FSA_SW_MASK_RST;
      sense_alert_mask <= FSA_SENSE_MASK_RST;
    end else if (cmd.wr && !cmd.rd) begin
      if (cmd.id == FSA_ID_HW_MASK) begin
        hw_alert_mask <= cmd.data;  // [R17]
      end else if (cmd.id == FSA_ID_LINK_MASK) begin
        link_alert_mask <= cmd.data;
      end else if (cmd.id == FSA_ID_SW_MASK) begin
        sw_alert_mask <= cmd.data;
      end else if (cmd.id == FSA_ID_SENSE_MASK) begin
        sense_alert_mask <= cmd.data;
      end
    end
  end

  // Command answer one cycle after the request; read wins no tie, both is an error
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp <= '0;
    end else begin
      rsp.done <= cmd.rd | cmd.wr;
      if (cmd.rd && cmd.wr) begin
        rsp.err  <= 1'b1;        // Ambiguous request, nothing done
        rsp.data <= 16'h0000;
      end else if (cmd.rd) begin
        rsp.err  <= ~id_known;
        rsp.data <= rd_value;
      end else if (cmd.wr) begin
        rsp.err  <= ~id_writable;  // Read-only field, write dropped [R22]
        rsp.data <= 16'h0000;
      end else begin
        rsp.err  <= 1'b0;
        rsp.data <= 16'h0000;
      end
    end
  end

endmodule : fsa_fault_status_aggregator

// [fsa_pkg.sv]
// Constants, carrier types and states shared by the fault status aggregator.
// Overview of operation
// R1 - Health bit 0 flags fatal error occurred.
// R2 - Health bit 1 ORs hardware error field.
// R3 - Health bit 2 ORs communication error field.
// R4 - Health bit 3 ORs software error field.
// R5 - Alert bit 8, hw/link/sw/sense 9-12.
// R6 - Hardware alert ORs condition AND mask.
// R7 - Hardware field bit 0 ORs rails.
// R8 - Hardware field bit 1 ORs environment.
// R9 - Rail field: nine soft flags, 9-15 reserved.
// R10 - Environment field: board temperature in bit 0.
// R11 - Link field bit 0 ORs port A.
// R12 - Port field: five soft flags, 5-15 reserved.
// R13 - Software field bit 0 ORs algorithm field.
// R14 - Software field bit 1 ORs data field.
// R15 - Algorithm field: three hard flags, 3-15 reserved.
// R16 - Data field bit 0: calibration checksum bad.
// R17 - Host programs masks to pick alerts.
// R18 - Soft errors fatal only after repeated hits.
// R19 - Fatal on hard failure or persistent soft.
// R20 - Fatal flag mirrored on fault pin.
// R21 - Overall alert ORs four alert flags.
// R22 - Reserved bits read zero, writes ignored.
// R23 - Threshold and window are per-flag parameters; here one SOFT_THRESH and one WINDOW_CYCLES serve all flags.
package fsa_pkg;

  // Field identifiers for the field-read and field-write commands
  localparam logic [15:0] FSA_ID_HW_MASK     = 16'h0010;
  localparam logic [15:0] FSA_ID_LINK_MASK   = 16'h0011;
  localparam logic [15:0] FSA_ID_SW_MASK     = 16'h0012;
  localparam logic [15:0] FSA_ID_SENSE_MASK  = 16'h0013;
  localparam logic [15:0] FSA_ID_HEALTH      = 16'h0100;
  localparam logic [15:0] FSA_ID_HW_SUM      = 16'h0101;
  localparam logic [15:0] FSA_ID_RAIL        = 16'h0102;
  localparam logic [15:0] FSA_ID_ENV         = 16'h0103;
  localparam logic [15:0] FSA_ID_LINK_SUM    = 16'h0104;
  localparam logic [15:0] FSA_ID_PORT        = 16'h0105;
  localparam logic [15:0] FSA_ID_SW_SUM      = 16'h0106;
  localparam logic [15:0] FSA_ID_ALGO        = 16'h0107;
  localparam logic [15:0] FSA_ID_CAL         = 16'h0108;
  localparam logic [15:0] FSA_ID_HW_COND     = 16'h0109;
  localparam logic [15:0] FSA_ID_LINK_COND   = 16'h010A;
  localparam logic [15:0] FSA_ID_SW_COND     = 16'h010B;
  localparam logic [15:0] FSA_ID_SENSE_COND  = 16'h010C;

  // Bit positions in the global health word
  localparam int FSA_GH_FATAL       = 0;
  localparam int FSA_GH_HW          = 1;
  localparam int FSA_GH_LINK        = 2;
  localparam int FSA_GH_SW          = 3;
  localparam int FSA_GH_ALERT       = 8;
  localparam int FSA_GH_HW_ALERT    = 9;
  localparam int FSA_GH_LINK_ALERT  = 10;
  localparam int FSA_GH_SW_ALERT    = 11;
  localparam int FSA_GH_SENSE_ALERT = 12;

  // Bit positions in the summary fields
  localparam int FSA_HW_RAIL   = 0;
  localparam int FSA_HW_ENV    = 1;
  localparam int FSA_LINK_PORT = 0;
  localparam int FSA_SW_ALGO   = 0;
  localparam int FSA_SW_CAL    = 1;

  // Widths of implemented bits in each field
  localparam int FSA_RAIL_W  = 9;
  localparam int FSA_PORT_W  = 5;
  localparam int FSA_ALGO_W  = 3;
  localparam int FSA_HWC_W   = 4;
  localparam int FSA_SWC_W   = 4;
  localparam int FSA_NUM_SOFT = 15;

  // Reset values of the enable masks and of every field
  localparam logic [15:0] FSA_HW_MASK_RST    = 16'h0000;
  localparam logic [15:0] FSA_LINK_MASK_RST  = 16'h0001;
  localparam logic [15:0] FSA_SW_MASK_RST    = 16'h0003;
  localparam logic [15:0] FSA_SENSE_MASK_RST = 16'h0001;
  localparam logic [15:0] FSA_FIELD_RST      = 16'h0000;

  // Soft-error qualification timing
  localparam int          FSA_CLK_PERIOD_NS  = 100;
  localparam int          FSA_WINDOW_NS      = 1000000;
  localparam int          FSA_WINDOW_CYCLES  = FSA_WINDOW_NS / FSA_CLK_PERIOD_NS;
  localparam int          FSA_WIN_CNT_W      = 24;
  localparam int          FSA_SOFT_CNT_W     = 8;
  localparam logic [7:0]  FSA_THRESH_DEFAULT = 8'h04;

  // Power rail flags, input power in bit 0
  typedef struct packed {
    logic ground_ref_oob;
    logic rail_6v_oob;
    logic ref_2v5_oob;
    logic rail_2v_oob;
    logic rail_3v_oob;
    logic rail_5v_oob;
    logic input_voltage_oob;
    logic input_current_oob;
    logic input_power_oob;
  } fsa_rail_t;

  // User serial port flags, transmit overflow in bit 0
  typedef struct packed {
    logic parity_fault;
    logic line_break_seen;
    logic frame_fault;
    logic rx_overflow;
    logic tx_overflow;
  } fsa_port_t;

  // Algorithm hard flags, initialisation failure in bit 0
  typedef struct packed {
    logic deadline_miss;
    logic sensor_saturation;
    logic init_fail;
  } fsa_algo_t;

  // Field command from the host side
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] id;
    logic [15:0] data;
  } fsa_cmd_t;

  // Field command answer
  typedef struct packed {
    logic        done;
    logic        err;
    logic [15:0] data;
  } fsa_rsp_t;

  // Health state, one-hot
  typedef enum logic [1:0] {
    FSA_HEALTHY = 2'b01,
    FSA_FAILED  = 2'b10
  } fsa_state_t;

endpackage : fsa_pkg

// [fsa_soft_persist.sv]
// Leaky occurrence counter that qualifies one soft error flag.
`timescale 1ns/1ns
module fsa_soft_persist
  import fsa_pkg::*;
#(
  parameter logic [7:0] THRESH = FSA_THRESH_DEFAULT
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic leak,
  input  wire logic flag_in,
  output logic      persist
);

  logic                      flag_q;  // Previous flag level for edge detect
  logic [FSA_SOFT_CNT_W-1:0] count;   // Occurrences not yet leaked away
  logic                      hit;     // New occurrence this cycle

  // Only rising edges count, so a flag stuck high counts once per assertion
  assign hit = flag_in & ~flag_q;

  // Edge history
  always_ff @(posedge clk) begin
    if (srst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_in;
    end
  end

  // High-pass counter: hits add, the window tick drains one
  always_ff @(posedge clk) begin
    if (srst) begin
      count <= '0;
    end else if (hit && !leak) begin
      if (count != {FSA_SOFT_CNT_W{1'b1}}) begin  // Saturate, never wrap [R18]
        count <= count + 1'b1;
      end
    end else if (leak && !hit && count != '0) begin
      count <= count - 1'b1;                      // [R18]
    end
  end

  // Threshold compare, registered
  always_ff @(posedge clk) begin
    if (srst) begin
      persist <= 1'b0;
    end else begin
      persist <= (count >= THRESH);  // [R18] [R23]
    end
  end

endmodule : fsa_soft_persist

// [testbench.sv]
// Self-checking bench for the fault status aggregator.
`timescale 1ns/1ns
module testbench;
  import fsa_pkg::*;
  logic        clk;
  logic        srst;
  fsa_rail_t   rail_in;
  logic        board_temp_oob;
  fsa_port_t   port_in;
  fsa_algo_t   algo_in;
  logic        cal_checksum_bad;
  logic [3:0]  hw_cond;
  logic        link_cond;
  logic [3:0]  sw_cond;
  logic        sense_cond;
  fsa_cmd_t    cmd;
  fsa_rsp_t    rsp;
  logic [15:0] health_word;
  logic        hw_fault_out;
  int          err_count;
  int          check_count;
  fsa_rsp_t    r;
  // Short window and threshold keep soft-error runs brief
  fsa_fault_status_aggregator #(.WINDOW_CYCLES(20), .SOFT_THRESH(8'h03)) i_dut (.*);
  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // One request, held for exactly one rising edge, then one idle edge
  task automatic access(input logic rd, input logic wr, input logic [15:0] id,
                        input logic [15:0] d);
    cmd = '{rd, wr, id, d};
    @(negedge clk);
    r = rsp;
    cmd = '0;
    @(negedge clk);
  endtask : access
  task automatic rd(input logic [15:0] id, input logic [15:0] exp);
    access(1'b1, 1'b0, id, 16'h0000);
    check(r, {2'b10, exp});
  endtask : rd
  task automatic do_reset;
    srst = 1'b1;
    cyc(12);
    srst = 1'b0;
  endtask : do_reset
  task automatic t_reset_vals;
    rd(FSA_ID_HW_MASK, FSA_HW_MASK_RST);
    rd(FSA_ID_LINK_MASK, FSA_LINK_MASK_RST);
    rd(FSA_ID_SW_MASK, FSA_SW_MASK_RST);
    rd(FSA_ID_SENSE_MASK, FSA_SENSE_MASK_RST);
    rd(FSA_ID_HEALTH, 16'h0000);
  endtask : t_reset_vals
  // Walk every soft flag alone through its field and summaries
  task automatic t_soft_tree;
    logic [15:0] f;
    for (int k = 0; k < 15; k++) begin
      f = 16'h0001 << (k < 9 ? k : (k < 10 ? 0 : k - 10));
      rail_in = (k < 9) ? fsa_rail_t'(f[8:0]) : '0;
      board_temp_oob = (k == 9);
      port_in = (k > 9) ? fsa_port_t'(f[4:0]) : '0;
      cyc(2);
      check({2'b00, health_word}, k < 10 ? 18'h00002 : 18'h00004);
      rd(k < 9 ? FSA_ID_RAIL : (k == 9 ? FSA_ID_ENV : FSA_ID_PORT), f);
      rd(k < 10 ? FSA_ID_HW_SUM : FSA_ID_LINK_SUM, k == 9 ? 16'h0002 : 16'h0001);
      rail_in = '0;
      board_temp_oob = 1'b0;
      port_in = '0;
      cyc(2);
      check({2'b00, health_word}, 18'h00000);
    end
  endtask : t_soft_tree
  // Mask table walk; each step after the first removes or adds one alert
  task automatic t_alerts;
    logic [15:0] ids [6] = '{FSA_ID_HW_MASK, FSA_ID_HW_MASK, FSA_ID_LINK_MASK,
                             FSA_ID_SW_MASK, FSA_ID_SENSE_MASK, FSA_ID_HW_MASK};
    logic [15:0] vals [6] = '{16'h0008, 16'h0004, 16'h0000, 16'h0001, 16'h0000, 16'h0000};
    logic [15:0] hw [6] = '{16'h1D00, 16'h1F00, 16'h1B00, 16'h1300, 16'h0300, 16'h0000};
    hw_cond = 4'h7;
    link_cond = 1'b1;
    sw_cond = 4'h2;
    sense_cond = 1'b1;
    cyc(3);
    check({2'b00, health_word}, 18'h01D00);
    rd(FSA_ID_HW_COND, 16'h0007);
    rd(FSA_ID_LINK_COND, 16'h0001);
    rd(FSA_ID_SW_COND, 16'h0002);
    rd(FSA_ID_SENSE_COND, 16'h0001);
    for (int i = 0; i < 6; i++) begin
      access(1'b0, 1'b1, ids[i], vals[i]);
      check({16'h0000, r.done, r.err}, 18'h00002);
      cyc(2);
      rd(ids[i], vals[i]);
      check({2'b00, health_word}, {2'b00, hw[i]});
    end
    access(1'b1, 1'b0, 16'h0200, 16'h0000);
    check(r, 18'h30000);
    access(1'b0, 1'b1, FSA_ID_HEALTH, 16'hFFFF);
    check({16'h0000, r.done, r.err}, 18'h00003);
    access(1'b1, 1'b1, FSA_ID_HW_MASK, 16'hFFFF);
    check({16'h0000, r.done, r.err}, 18'h00003);
    rd(FSA_ID_HW_MASK, 16'h0000);
    hw_cond = 4'h0;
    link_cond = 1'b0;
    sw_cond = 4'h0;
    sense_cond = 1'b0;
    cyc(2);
  endtask : t_alerts
  task automatic pulse(input int n);
    repeat (n) begin
      rail_in.rail_5v_oob = 1'b1;
      cyc(1);
      rail_in.rail_5v_oob = 1'b0;
      cyc(1);
    end
  endtask : pulse
  // Two hits leak away over three windows; four quick hits qualify
  task automatic t_soft_fatal;
    pulse(2);
    cyc(60);
    pulse(2);
    cyc(8);
    check({17'h00000, hw_fault_out}, 18'h00000);
    pulse(4);
    cyc(8);
    check({2'b00, health_word}, 18'h00001);
    check({17'h00000, hw_fault_out}, 18'h00001);
  endtask : t_soft_fatal
  // Each hard source alone is fatal at once and stays so
  task automatic t_hard;
    for (int k = 0; k < 4; k++) begin
      do_reset();
      if (k < 3)
        algo_in = fsa_algo_t'(3'b001 << k);
      else
        cal_checksum_bad = 1'b1;
      cyc(2);
      check({2'b00, health_word}, 18'h00008);
      rd(k < 3 ? FSA_ID_ALGO : FSA_ID_CAL, k < 3 ? 16'h0001 << k : 16'h0001);
      rd(FSA_ID_SW_SUM, k < 3 ? 16'h0001 : 16'h0002);
      algo_in = '0;
      cal_checksum_bad = 1'b0;
      cyc(3);
      check({2'b00, health_word}, 18'h00001);
      check({17'h00000, hw_fault_out}, 18'h00001);
    end
  endtask : t_hard
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  // Watchdog well past the expected run of about 375 cycles
  initial begin
    #400000;
    err_count++;
    final_report();
  end
  initial begin
    {rail_in, board_temp_oob, port_in, algo_in, cal_checksum_bad} = '0;
    {hw_cond, link_cond, sw_cond, sense_cond} = '0;
    cmd = '0;
    err_count = 0;
    check_count = 0;
    do_reset();
    t_reset_vals();
    t_soft_tree();
    t_alerts();
    t_soft_fatal();
    t_hard();
    final_report();
  end
endmodule : testbench
